//--- include/stid_pkg.sv
// Purpose: Shared constants and types for the system-table instruction decoder
// Assumes: Core clock at 10 MHz; all inputs synchronous
// Notes:   Opcode bytes, reg fields, clock counts and fault vectors live here
package stid_pkg;

  // Opcode bytes
  localparam logic [7:0] ESC_BYTE      = 8'h0f;
  localparam logic [7:0] GRP_TASK_BYTE = 8'h00;
  localparam logic [7:0] GRP_TBL_BYTE  = 8'h01;
  localparam logic [7:0] LSL_BYTE      = 8'h03;

  // Reg field codes, task/local group (second byte 00h)
  localparam logic [2:0] REG_STORE_LOCAL_TABLE_OP_F = 3'h0;
  localparam logic [2:0] REG_STR_F  = 3'h1;
  localparam logic [2:0] REG_LOAD_LOCAL_TABLE_OP_F = 3'h2;
  localparam logic [2:0] REG_LTR_F  = 3'h3;
  localparam logic [2:0] REG_VRD_F  = 3'h4;
  localparam logic [2:0] REG_VWR_F  = 3'h5;
  // Reg field codes, table group (second byte 01h)
  localparam logic [2:0] REG_STORE_GLOBAL_TABLE_OP_F = 3'h0;
  localparam logic [2:0] REG_STORE_VECTOR_TABLE_OP_F = 3'h1;
  localparam logic [2:0] REG_STORE_STATUS_WORD_OP_F = 3'h4;
  localparam logic [2:0] REG_LOAD_STATUS_WORD_OP_F = 3'h6;

  // Mod field value that selects a register operand
  localparam logic [1:0] MOD_REG = 2'h3;

  // Fault vectors
  localparam logic [7:0] VEC_UD = 8'h06;
  localparam logic [7:0] VEC_SS = 8'h0c;
  localparam logic [7:0] VEC_GP = 8'h0d;

  // Real-mode segment ceiling
  localparam logic [16:0] SEG_MAX = 17'h0ffff;

  // Clock counts, register/memory
  localparam logic [5:0] CLK_LOAD_STATUS_WORD_OP_R = 6'd11;
  localparam logic [5:0] CLK_LOAD_STATUS_WORD_OP_M = 6'd14;
  localparam logic [5:0] CLK_STORE_STATUS_WORD_OP   = 6'd2;
  localparam logic [5:0] CLK_STR    = 6'd2;
  localparam logic [5:0] CLK_STORE_LOCAL_TABLE_OP   = 6'd2;
  localparam logic [5:0] CLK_VRD_R  = 6'd10;
  localparam logic [5:0] CLK_VRD_M  = 6'd11;
  localparam logic [5:0] CLK_VWR_R  = 6'd15;
  localparam logic [5:0] CLK_VWR_M  = 6'd16;
  localparam logic [5:0] CLK_STBL   = 6'd9;
  localparam logic [5:0] CLK_LOAD_LOCAL_TABLE_OP_R = 6'd20;
  localparam logic [5:0] CLK_LOAD_LOCAL_TABLE_OP_M = 6'd24;
  localparam logic [5:0] CLK_LTR_R  = 6'd23;
  localparam logic [5:0] CLK_LTR_M  = 6'd27;
  localparam logic [5:0] CLK_LSL_R  = 6'd21;
  localparam logic [5:0] CLK_LSL_M  = 6'd22;
  localparam logic [5:0] CLK_FAULT  = 6'd1;

  typedef enum logic [3:0] {
    STID_OP_NONE = 4'h0,
    STID_OP_LOAD_STATUS_WORD_OP = 4'h1,
    STID_OP_STORE_STATUS_WORD_OP = 4'h2,
    STID_OP_STR  = 4'h3,
    STID_OP_LTR  = 4'h4,
    STID_OP_STORE_LOCAL_TABLE_OP = 4'h5,
    STID_OP_LOAD_LOCAL_TABLE_OP = 4'h6,
    STID_OP_STORE_GLOBAL_TABLE_OP = 4'h7,
    STID_OP_STORE_VECTOR_TABLE_OP = 4'h8,
    STID_OP_LSL  = 4'h9,
    STID_OP_VRD  = 4'ha,
    STID_OP_VWR  = 4'hb
  } stid_op_t;

  // Instruction as presented by the prefetch/decode front end
  typedef struct packed {
    logic [7:0]  firstByte;
    logic [7:0]  secondByte;
    logic [1:0]  modField;
    logic [2:0]  regField;
    logic        stackSeg;     // Operand addressed through the stack segment
    logic [15:0] operandOfs;   // Operand offset in its segment
    logic [2:0]  operandLen;   // Operand length in bytes, 1..6
  } stid_instr_t;

  // Result of one decode
  typedef struct packed {
    stid_op_t   op;
    logic       protOnly;
    logic       privileged;
    logic       verify;        // Access-verify or limit-load class
    logic       descLock;      // Touches descriptor tables
    logic [5:0] clocks;
  } stid_dec_t;

  // Per-cycle protection context
  typedef struct packed {
    logic       realMode;
    logic [1:0] currentPrivilegeLevel;
    logic       limitFault;    // Protected-mode limit violation
    logic       rightsFault;   // Protected-mode access-rights violation
    logic       selectorBad;   // Selector fails privilege rules
  } stid_ctx_t;

endpackage : stid_pkg

//--- hw/stid_decode.sv
// Purpose: Combinational opcode decode and clock-count selection
// Assumes: Instruction fields stable while decoding
// Notes:   Pure logic; the timing core registers its result
`timescale 1ns/100ps
`default_nettype none
module stid_decode (
  input  wire stid_pkg::stid_instr_t instr,
  output var  stid_pkg::stid_dec_t   dec
);

  // Pick register or memory count from the mod field
  function automatic logic [5:0] pick(input logic isReg, input logic [5:0] r,
                                      input logic [5:0] m);
    pick = isReg ? r : m;
  endfunction : pick

  wire isEsc  = instr.firstByte == stid_pkg::ESC_BYTE;
  wire grpTsk = isEsc && instr.secondByte == stid_pkg::GRP_TASK_BYTE;
  wire grpTbl = isEsc && instr.secondByte == stid_pkg::GRP_TBL_BYTE;
  wire isLsl  = isEsc && instr.secondByte == stid_pkg::LSL_BYTE;
  wire isReg  = instr.modField == stid_pkg::MOD_REG;

  // Opcode decode with per-operand clock counts
  always_comb begin
    dec = '0;
    dec.op = stid_pkg::STID_OP_NONE;
    if (grpTsk) begin
      unique case (instr.regField)
        stid_pkg::REG_STORE_LOCAL_TABLE_OP_F: begin
          dec.op = stid_pkg::STID_OP_STORE_LOCAL_TABLE_OP;
          dec.clocks = stid_pkg::CLK_STORE_LOCAL_TABLE_OP;
        end
        stid_pkg::REG_STR_F: begin
          dec.op = stid_pkg::STID_OP_STR;
          dec.clocks = stid_pkg::CLK_STR;
        end
        stid_pkg::REG_LOAD_LOCAL_TABLE_OP_F: begin
          dec.op = stid_pkg::STID_OP_LOAD_LOCAL_TABLE_OP;
          dec.clocks = pick(isReg, stid_pkg::CLK_LOAD_LOCAL_TABLE_OP_R, stid_pkg::CLK_LOAD_LOCAL_TABLE_OP_M);
        end
        stid_pkg::REG_LTR_F: begin
          dec.op = stid_pkg::STID_OP_LTR;
          dec.clocks = pick(isReg, stid_pkg::CLK_LTR_R, stid_pkg::CLK_LTR_M);
        end
        stid_pkg::REG_VRD_F: begin
          dec.op = stid_pkg::STID_OP_VRD;
          dec.clocks = pick(isReg, stid_pkg::CLK_VRD_R, stid_pkg::CLK_VRD_M);
        end
        stid_pkg::REG_VWR_F: begin
          dec.op = stid_pkg::STID_OP_VWR;
          dec.clocks = pick(isReg, stid_pkg::CLK_VWR_R, stid_pkg::CLK_VWR_M);
        end
        default: dec.op = stid_pkg::STID_OP_NONE;
      endcase
    end else if (grpTbl) begin
      unique case (instr.regField)
        stid_pkg::REG_STORE_GLOBAL_TABLE_OP_F: begin
          dec.op = stid_pkg::STID_OP_STORE_GLOBAL_TABLE_OP;
          dec.clocks = stid_pkg::CLK_STBL;
        end
        stid_pkg::REG_STORE_VECTOR_TABLE_OP_F: begin
          dec.op = stid_pkg::STID_OP_STORE_VECTOR_TABLE_OP;
          dec.clocks = stid_pkg::CLK_STBL;
        end
        stid_pkg::REG_STORE_STATUS_WORD_OP_F: begin
          dec.op = stid_pkg::STID_OP_STORE_STATUS_WORD_OP;
          dec.clocks = stid_pkg::CLK_STORE_STATUS_WORD_OP;
        end
        stid_pkg::REG_LOAD_STATUS_WORD_OP_F: begin
          dec.op = stid_pkg::STID_OP_LOAD_STATUS_WORD_OP;
          dec.clocks = pick(isReg, stid_pkg::CLK_LOAD_STATUS_WORD_OP_R, stid_pkg::CLK_LOAD_STATUS_WORD_OP_M);
        end
        default: dec.op = stid_pkg::STID_OP_NONE;
      endcase
    end else if (isLsl) begin
      dec.op = stid_pkg::STID_OP_LSL;
      dec.clocks = pick(isReg, stid_pkg::CLK_LSL_R, stid_pkg::CLK_LSL_M);
    end
    // Class attributes
    dec.protOnly = dec.op inside {stid_pkg::STID_OP_STR, stid_pkg::STID_OP_LTR,
                                  stid_pkg::STID_OP_STORE_LOCAL_TABLE_OP, stid_pkg::STID_OP_LOAD_LOCAL_TABLE_OP,
                                  stid_pkg::STID_OP_LSL, stid_pkg::STID_OP_VRD,
                                  stid_pkg::STID_OP_VWR};
    dec.privileged = dec.op inside {stid_pkg::STID_OP_LOAD_STATUS_WORD_OP, stid_pkg::STID_OP_LTR,
                                    stid_pkg::STID_OP_LOAD_LOCAL_TABLE_OP};
    dec.verify = dec.op inside {stid_pkg::STID_OP_LSL, stid_pkg::STID_OP_VRD,
                                stid_pkg::STID_OP_VWR};
    dec.descLock = dec.verify || dec.op inside {stid_pkg::STID_OP_LTR,
                                                stid_pkg::STID_OP_LOAD_LOCAL_TABLE_OP};
  end

endmodule : stid_decode
`default_nettype wire

//--- hw/stid_fault_check.sv
// Purpose: Fault classification for one decoded instruction
// Assumes: Context and operand fields valid with the start strobe
// Notes:   Priority: invalid opcode, then privilege, then limits
`timescale 1ns/100ps
`default_nettype none
module stid_fault_check (
  input  wire stid_pkg::stid_instr_t instr,
  input  wire stid_pkg::stid_dec_t   dec,
  input  wire stid_pkg::stid_ctx_t   ctx,
  output var  logic                  fault,
  output var  logic [7:0]            vector,
  output var  logic                  zeroClear
);

  // Last byte touched, one bit wider so a wrap past the ceiling shows
  wire [16:0] lastByte = {1'b0, instr.operandOfs} + {14'h0, instr.operandLen} - 17'h1;
  wire memOp     = instr.modField != stid_pkg::MOD_REG;
  wire realOver  = ctx.realMode && memOp && instr.operandLen != 3'h0 &&
                   lastByte > stid_pkg::SEG_MAX;
  wire udFault   = ctx.realMode && dec.protOnly;
  wire privFault = !ctx.realMode && dec.privileged &&
                   ctx.currentPrivilegeLevel != 2'h0;
  wire protMem   = !ctx.realMode && memOp && (ctx.limitFault || ctx.rightsFault);

  // Prioritised vector selection
  always_comb begin
    fault = 1'b1;
    vector = 8'h00;
    if (udFault)
      vector = stid_pkg::VEC_UD;
    else if (privFault)
      vector = stid_pkg::VEC_GP;
    else if (realOver)
      vector = instr.stackSeg ? stid_pkg::VEC_SS : stid_pkg::VEC_GP;
    else if (protMem)
      vector = (instr.stackSeg && ctx.limitFault) ? stid_pkg::VEC_SS
                                                   : stid_pkg::VEC_GP;
    else
      fault = 1'b0;
  end

  // Selector privilege failure only clears the zero flag, no exception
  assign zeroClear = !udFault && dec.verify && ctx.selectorBad;

endmodule : stid_fault_check
`default_nettype wire

//--- hw/stid_core.sv
// Purpose: System-table instruction sequencer: decode, faults, timing, bus lock
// Assumes: One instruction at a time; start is a one-cycle pulse while idle
// Notes:   Outputs are all registered; busy spans the instruction's clock count
`timescale 1ns/100ps
`default_nettype none

module stid_core (
  input  wire  logic                  clk,
  input  wire  logic                  rst,
  input  wire  logic                  start,
  input  wire  stid_pkg::stid_instr_t instr,
  input  wire  stid_pkg::stid_ctx_t   ctx,
  input  wire  logic                  lockPrefix,
  input  wire  logic                  descAccess,
  output logic                        busy,
  output logic                        done,
  output logic                        faultValid,
  output logic [7:0]                  faultVector,
  output logic                        zeroFlagClear,
  output logic                        busLock,
  output logic [3:0]                  opCode
);

  typedef enum logic [2:0] {
    STID_IDLE  = 3'b001,
    STID_EXEC  = 3'b010,
    STID_FAULT = 3'b100
  } stid_state_t;

  stid_pkg::stid_dec_t dec;
  logic                fault;
  logic [7:0]          vector;
  logic                zeroClear;
  stid_state_t         state_reg;
  stid_state_t         state_next;
  logic [5:0]          count_reg;
  logic [5:0]          count_next;
  logic                autoLock_reg;
  logic                prefix_reg;

  stid_decode uDecode (
    .instr (instr),
    .dec   (dec)
  );

  stid_fault_check uFault (
    .instr     (instr),
    .dec       (dec),
    .ctx       (ctx),
    .fault     (fault),
    .vector    (vector),
    .zeroClear (zeroClear)
  );

  // Accept only recognised instructions while idle
  wire accept   = start && state_reg == STID_IDLE && dec.op != stid_pkg::STID_OP_NONE;
  wire lastTick = state_reg == STID_EXEC && count_reg == 6'd1;

  // Next state; faulting instructions spend one cycle reporting
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    unique case (state_reg)
      STID_IDLE: begin
        if (accept && fault) begin
          state_next = STID_FAULT;
          count_next = stid_pkg::CLK_FAULT;
        end else if (accept) begin
          state_next = STID_EXEC;
          count_next = dec.clocks;
        end
      end
      STID_EXEC: begin
        count_next = count_reg - 6'd1;
        if (lastTick)
          state_next = STID_IDLE;
      end
      STID_FAULT: begin
        state_next = STID_IDLE;
        count_next = 6'd0;
      end
      default: begin
        state_next = STID_IDLE;
        count_next = 6'd0;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= STID_IDLE;
      count_reg <= 6'h00;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // Lock attributes captured with the instruction
  always_ff @(posedge clk) begin
    if (rst) begin
      autoLock_reg <= 1'b0;
      prefix_reg   <= 1'b0;
    end else if (accept) begin
      autoLock_reg <= dec.descLock && !fault;
      prefix_reg   <= lockPrefix;
    end
  end

  // Lock follows descriptor accesses; the prefix is not needed for it
  wire lockNext = state_next == STID_EXEC && descAccess &&
                  (accept ? dec.descLock && !fault : autoLock_reg);

  // Registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      busy          <= 1'b0;
      done          <= 1'b0;
      faultValid    <= 1'b0;
      faultVector   <= 8'h00;
      zeroFlagClear <= 1'b0;
      busLock       <= 1'b0;
      opCode        <= 4'h0;
    end else begin
      busy          <= state_next == STID_EXEC;
      done          <= lastTick;
      faultValid    <= accept && fault;
      faultVector   <= (accept && fault) ? vector : faultVector;
      zeroFlagClear <= accept && !fault && zeroClear;
      busLock       <= lockNext;
      opCode        <= accept ? dec.op : opCode;
    end
  end

  // Length of the current busy run; long runs are checked on this, not by repetition
  logic [5:0] busyRun_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      busyRun_reg <= 6'h00;
    end else begin
      busyRun_reg <= busy ? busyRun_reg + 6'h01 : 6'h00;
    end
  end

  // Invalid opcode comes out the cycle after a real-mode start
  real_ud_a: assert property (@(posedge clk) disable iff (rst)
    accept && ctx.realMode && dec.protOnly |=> faultValid && faultVector == 8'h06)
    else $error("invalid opcode not raised");

  // Status-word load from register runs eleven busy cycles without a gap
  load_status_word_op_time_a: assert property (@(posedge clk) disable iff (rst)
    accept && !fault && dec.op == stid_pkg::STID_OP_LOAD_STATUS_WORD_OP &&
    instr.modField == 2'h3 |=> ##11 (!busy && busyRun_reg == 6'd11))
    else $error("status word load timing wrong");

  // Memory operand status-word load takes fourteen
  load_status_word_op_mem_a: assert property (@(posedge clk) disable iff (rst)
    accept && !fault && dec.op == stid_pkg::STID_OP_LOAD_STATUS_WORD_OP &&
    instr.modField != 2'h3 |=> ##13 busy ##1 !busy)
    else $error("status word memory timing wrong");

  // Task and local stores take two clocks
  store_two_a: assert property (@(posedge clk) disable iff (rst)
    accept && !fault && (dec.op == stid_pkg::STID_OP_STR ||
    dec.op == stid_pkg::STID_OP_STORE_LOCAL_TABLE_OP) |=> busy [*2] ##1 (!busy && done))
    else $error("store timing wrong");

  // Read verify memory operand takes eleven
  verify_read_access_op_time_a: assert property (@(posedge clk) disable iff (rst)
    accept && !fault && dec.op == stid_pkg::STID_OP_VRD &&
    instr.modField != 2'h3 |=> ##10 busy ##1 !busy)
    else $error("read verify timing wrong");

  // Global-table store takes nine in either mode
  table_nine_a: assert property (@(posedge clk) disable iff (rst)
    accept && !fault && dec.op == stid_pkg::STID_OP_STORE_GLOBAL_TABLE_OP |=> ##8 busy ##1 !busy)
    else $error("table store timing wrong");

  // Real-mode stack overrun gives vector 12
  stack_over_a: assert property (@(posedge clk) disable iff (rst)
    accept && fault && vector == 8'h0c |=> faultValid && faultVector == 8'h0c &&
    !busy) else $error("stack fault not reported");

  // Nonzero privilege on privileged ops in protected mode gives vector 13
  priv_gp_a: assert property (@(posedge clk) disable iff (rst)
    accept && !ctx.realMode && dec.privileged && ctx.currentPrivilegeLevel != 2'h0
    |=> faultValid && faultVector == 8'h0d)
    else $error("privilege fault missing");

  // Selector failure never raises an exception
  zero_noexc_a: assert property (@(posedge clk) disable iff (rst)
    zeroFlagClear |-> !faultValid && $past(ctx.selectorBad))
    else $error("zero flag path raised fault");

  // Bus lock only while a descriptor-locking instruction executes
  lock_scope_a: assert property (@(posedge clk) disable iff (rst)
    busLock |-> busy && (opCode == 4'h4 || opCode == 4'h6 || opCode >= 4'h9))
    else $error("bus lock outside descriptor access");

  // Real-mode data overrun gives general protection
  real_gp_a: assert property (@(posedge clk) disable iff (rst)
    accept && ctx.realMode && !dec.protOnly && fault && !instr.stackSeg
    |=> faultVector == 8'h0d) else $error("real mode limit fault wrong");

  // Register operand read verify takes ten
  verify_read_access_op_reg_a: assert property (@(posedge clk) disable iff (rst)
    accept && !fault && dec.op == stid_pkg::STID_OP_VRD &&
    instr.modField == 2'h3 |=> ##10 (!busy && busyRun_reg == 6'd10))
    else $error("read verify register timing wrong");

  // Status-word store runs two cycles in either mode
  store_status_word_op_two_a: assert property (@(posedge clk) disable iff (rst)
    accept && !fault && dec.op == stid_pkg::STID_OP_STORE_STATUS_WORD_OP
    |=> ##2 (!busy && busyRun_reg == 6'd2))
    else $error("status word store timing wrong");

  // Vector-table store also takes nine
  vector_nine_a: assert property (@(posedge clk) disable iff (rst)
    accept && !fault && dec.op == stid_pkg::STID_OP_STORE_VECTOR_TABLE_OP
    |=> ##9 (!busy && busyRun_reg == 6'd9))
    else $error("vector table store timing wrong");

  // Real-mode capable instructions without a limit overrun execute instead of faulting
  real_exec_a: assert property (@(posedge clk) disable iff (rst)
    accept && ctx.realMode && !dec.protOnly && !fault |=> busy && !faultValid)
    else $error("real mode instruction not executed");

  // A faulting instruction never executes or locks
  fault_quiet_a: assert property (@(posedge clk) disable iff (rst)
    faultValid |-> !busy && !busLock)
    else $error("fault cycle shows execution");

  // Fault report is a single-cycle pulse
  fault_once_a: assert property (@(posedge clk) disable iff (rst)
    faultValid |=> !faultValid)
    else $error("fault pulse too long");

  // Selector failure on a verify op clears the zero flag
  zero_set_a: assert property (@(posedge clk) disable iff (rst)
    accept && !fault && dec.verify && ctx.selectorBad |=> zeroFlagClear)
    else $error("zero flag clear missing");

  // Other instructions never touch the zero flag
  zero_other_a: assert property (@(posedge clk) disable iff (rst)
    accept && !fault && !dec.verify |=> !zeroFlagClear)
    else $error("zero flag cleared by wrong op");

  // Descriptor access in the first cycle already locks, prefix or not
  lock_first_a: assert property (@(posedge clk) disable iff (rst)
    accept && !fault && dec.descLock && descAccess |=> busLock)
    else $error("bus lock missing on first access");

  // Protected-mode rights violation on a memory operand gives vector 13
  prot_rights_a: assert property (@(posedge clk) disable iff (rst)
    accept && !ctx.realMode && !dec.privileged && instr.modField != 2'h3 &&
    ctx.rightsFault && !ctx.limitFault |=> faultValid && faultVector == 8'h0d)
    else $error("protected rights fault wrong");

  // Completion pulse follows the last busy cycle
  done_end_a: assert property (@(posedge clk) disable iff (rst)
    done |-> !busy && $past(busy))
    else $error("done outside end of execution");

  cov_load_status_word_op_c: cover property (@(posedge clk) disable iff (rst)
    accept && dec.op == stid_pkg::STID_OP_LOAD_STATUS_WORD_OP ##1 busy);
  cov_ud_c: cover property (@(posedge clk) disable iff (rst)
    faultValid && faultVector == 8'h06);
  cov_lock_c: cover property (@(posedge clk) disable iff (rst) busLock);
  cov_zero_c: cover property (@(posedge clk) disable iff (rst) zeroFlagClear);
  cov_noprefix_c: cover property (@(posedge clk) disable iff (rst) busLock && !prefix_reg);

endmodule : stid_core
`default_nettype wire

//--- verification/stid_tb.sv
// Purpose: Self-checking bench for the system-table instruction sequencer
// Assumes: Assertions live in the design files; inputs change 1 ns after edges
// Notes:   Model predicts op, count, fault and lock; sweeps every code and mode
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                  clk;
  logic                  rst;
  logic                  start;
  stid_pkg::stid_instr_t instr;
  stid_pkg::stid_ctx_t   ctx;
  logic                  lockPrefix;
  logic                  descAccess;
  logic                  busy;
  logic                  done;
  logic                  faultValid;
  logic [7:0]            faultVector;
  logic                  zeroFlagClear;
  logic                  busLock;
  logic [3:0]            opCode;
  int                    err_count;
  int                    comparisons;
  logic [31:0]           seed;
  logic [7:0]            expOp;
  logic [7:0]            expN;
  logic [7:0]            expVec;
  logic                  expZc;
  logic                  expLk;

  stid_core uut (
    .clk           (clk),
    .rst           (rst),
    .start         (start),
    .instr         (instr),
    .ctx           (ctx),
    .lockPrefix    (lockPrefix),
    .descAccess    (descAccess),
    .busy          (busy),
    .done          (done),
    .faultValid    (faultValid),
    .faultVector   (faultVector),
    .zeroFlagClear (zeroFlagClear),
    .busLock       (busLock),
    .opCode        (opCode)
  );

  // 10 MHz core clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Xorshift source; fixed start keeps runs repeatable
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // Reference decode: flags are protected-only, privileged, verify, auto-lock
  task automatic model();
    logic [7:0] rc;
    logic [7:0] mc;
    logic [3:0] fl;
    logic       mem;
    mem = (instr.modField != 2'h3);
    {expOp, rc, mc, fl} = '0;
    if (instr.firstByte == 8'h0f && instr.secondByte[7:2] == 6'h00) begin
      casez ({instr.secondByte[1:0], instr.regField})
        5'h00: {expOp, rc, mc, fl} = {8'h05, 8'h02, 8'h02, 4'h8};
        5'h01: {expOp, rc, mc, fl} = {8'h03, 8'h02, 8'h02, 4'h8};
        5'h02: {expOp, rc, mc, fl} = {8'h06, 8'h14, 8'h18, 4'hd};
        5'h03: {expOp, rc, mc, fl} = {8'h04, 8'h17, 8'h1b, 4'hd};
        5'h04: {expOp, rc, mc, fl} = {8'h0a, 8'h0a, 8'h0b, 4'hb};
        5'h05: {expOp, rc, mc, fl} = {8'h0b, 8'h0f, 8'h10, 4'hb};
        5'h08: {expOp, rc, mc, fl} = {8'h07, 8'h09, 8'h09, 4'h0};
        5'h09: {expOp, rc, mc, fl} = {8'h08, 8'h09, 8'h09, 4'h0};
        5'h0c: {expOp, rc, mc, fl} = {8'h02, 8'h02, 8'h02, 4'h0};
        5'h0e: {expOp, rc, mc, fl} = {8'h01, 8'h0b, 8'h0e, 4'h4};
        5'b11???: {expOp, rc, mc, fl} = {8'h09, 8'h15, 8'h16, 4'hb};
        default: expOp = 8'h00;
      endcase
    end
    expN = mem ? mc : rc;
    expVec = 8'h00;
    if (ctx.realMode && fl[3]) expVec = 8'h06;
    else if (!ctx.realMode && fl[2] && ctx.currentPrivilegeLevel != 2'h0) expVec = 8'h0d;
    else if (ctx.realMode && mem && ({1'b0, instr.operandOfs} + instr.operandLen - 1 > 17'h0ffff))
      expVec = instr.stackSeg ? 8'h0c : 8'h0d;
    else if (!ctx.realMode && mem && (ctx.limitFault || ctx.rightsFault))
      expVec = (instr.stackSeg && ctx.limitFault) ? 8'h0c : 8'h0d;
    expZc = (expVec == 8'h00) && fl[1] && ctx.selectorBad;
    expLk = fl[0];
  endtask : model

  // One instruction: pulse start, then follow it cycle by cycle
  task automatic run_op();
    int   n;
    logic prevD;
    model();
    void'(rnd());
    descAccess = seed[3];
    lockPrefix = seed[9];
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    if (expOp == 8'h00) begin
      check("idle", busy, 16'h0000);
      return;
    end
    if (expVec != 8'h00) begin
      check("faultValid", faultValid, 16'h0001);
      check("faultVector", faultVector, expVec);
      check("busy", busy, 16'h0000);
      check("faultLock", busLock, 16'h0000);
      @(posedge clk);
      #1 check("faultPulse", faultValid, 16'h0000);
      return;
    end
    check("zeroFlagClear", zeroFlagClear, expZc);
    check("opCode", opCode, expOp[3:0]);
    n = 0;
    prevD = descAccess;
    // Retry start in cycle 2: it must be refused while busy
    while (busy === 1'b1 && n < 40) begin
      n++;
      check("done", done, 16'h0000);
      check("busLock", busLock, prevD & expLk);
      void'(rnd());
      prevD = seed[3];
      descAccess = prevD;
      lockPrefix = seed[9];
      start = (n == 2);
      @(posedge clk);
      #1;
    end
    start = 1'b0;
    descAccess = 1'b0;
    check("busyCycles", n[15:0], expN);
    check("doneEnd", done, 16'h0001);
    if (n >= 40) begin
      err_count++;
      report_and_stop();
    end
  endtask : run_op

  // Memory operand: real mode near the segment ceiling, or protected with limit/rights faults
  task automatic edge_case(input logic rm, input logic stk, input logic [15:0] ofs,
                           input logic [2:0] len, input logic lim, input logic rts);
    instr = '{8'h0f, 8'h01, 2'h0, 3'h0, stk, ofs, len};
    ctx = '{rm, 2'h0, lim, rts, 1'b0};
    run_op();
  endtask : edge_case

  // Reset, full sweep of codes and modes, then limit boundaries
  initial begin
    err_count = 0;
    comparisons = 0;
    seed = 32'h3c1f;
    rst = 1'b1;
    start = 1'b0;
    instr = '0;
    ctx = '0;
    lockPrefix = 1'b0;
    descAccess = 1'b0;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    check("rstBusy", busy, 16'h0000);
    check("rstLock", busLock, 16'h0000);
    check("rstOp", opCode, 16'h0000);
    for (int sb = 0; sb < 4; sb++) begin
      for (int rg = 0; rg < 8; rg++) begin
        for (int m = 0; m < 4; m++) begin
          void'(rnd());
          instr.firstByte = 8'h0f;
          instr.secondByte = sb[7:0];
          instr.regField = rg[2:0];
          instr.modField = m[0] ? 2'h3 : {seed[0], 1'b0};
          instr.stackSeg = seed[4];
          instr.operandOfs = {1'b0, seed[14:0]};
          instr.operandLen = 3'h2;
          ctx = '{m[1], seed[8] ? seed[6:5] : 2'h0, 1'b0, 1'b0, seed[10]};
          run_op();
        end
      end
    end
    edge_case(1'b1, 1'b0, 16'hffff, 3'h1, 1'b0, 1'b0);
    edge_case(1'b1, 1'b0, 16'hffff, 3'h2, 1'b0, 1'b0);
    edge_case(1'b1, 1'b1, 16'hfffe, 3'h4, 1'b0, 1'b0);
    edge_case(1'b1, 1'b1, 16'hfffa, 3'h6, 1'b0, 1'b0);
    edge_case(1'b0, 1'b1, 16'h0010, 3'h2, 1'b1, 1'b0);
    edge_case(1'b0, 1'b1, 16'h0010, 3'h2, 1'b0, 1'b1);
    edge_case(1'b0, 1'b0, 16'h0010, 3'h2, 1'b1, 1'b0);
    instr.firstByte = 8'h0e;
    run_op();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
